//--- core/mtr_ctrl.sv
// Meter trigger, range and function control with Avalon-MM registers
`timescale 1ns/1ps
`default_nettype none

module mtr_ctrl #(
  parameter int unsigned DELAY_CYCLES = mtr_pkg::TRIG_DELAY_CYCLES,
  parameter int unsigned HOLD_CYCLES = mtr_pkg::COMMIT_HOLD_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Front panel key strobes and range key level
  input wire logic func_key_valid,
  input wire logic [2:0] func_key_code,
  input wire logic sec_key_valid,
  input wire logic [2:0] sec_key_code,
  input wire logic mod_key_valid,
  input wire logic [1:0] mod_key_code,
  input wire logic key_range,
  input wire logic range_key_level,
  input wire logic key_up,
  input wire logic key_down,
  input wire logic key_shift,
  input wire logic key_rate_trig,
  // Rear serial trigger connector
  input wire logic ext_trig_in,
  output logic trig_out_n,
  // Measurement engine
  output logic meas_start,
  input wire logic meas_done,
  input wire logic meas_over_full_scale,
  input wire logic meas_under_lower,
  input wire logic meas_below_20_ohm,
  input wire logic meas_diode_over_2v,
  input wire logic lead_ma,
  input wire logic lead_10a,
  // Display and annunciators
  output logic [2:0] func,
  output logic [2:0] range,
  output logic auto_range,
  output logic overload_indication,
  output logic wire4_annunc,
  output logic amp_group_annunc,
  output logic ext_trig_annunc,
  output logic [1:0] rate,
  output logic [3:0] mods_active,
  output logic [2:0] sec_func,
  output logic sec_on,
  output logic menu_active,
  output logic [2:0] menu_mode,
  output logic beeper
);

  typedef struct packed {
    mtr_pkg::mtr_trig_state_type trig_state;
    logic [2:0] trig_mode;
    logic [2:0] menu_mode;
    logic menu;
    logic shift;
    logic [27:0] delay_cnt;
    logic [27:0] hold_cnt;
    logic [7:0] pulse_cnt;
    logic meas_start;
    logic trig_out_n;
    logic [2:0] func;
    logic func_chosen;
    logic [2:0] sec_func;
    logic sec_on;
    logic [2:0] range;
    logic auto_range;
    logic overload;
    logic wire4;
    logic [3:0] mods;
    logic [1:0] rate_sel;
    logic [1:0] rate;
    logic beeper;
    logic amp_group;
    logic ext_annunc;
    logic waitrequest;
    logic [31:0] readdata;
    logic [15:0] done_count;
  } mtr_ctrl_reg_type;

  mtr_ctrl_reg_type r;
  mtr_ctrl_reg_type next_r;
  logic ext_strobe;

  // ==========================================================
  // External trigger conditioning
  mtr_trig_sync u_trig_sync (
    .clk(clk),
    .rst(rst),
    .trig_in(ext_trig_in),
    .trig_strobe(ext_strobe)
  );

  // ==========================================================
  // Range limits per function and terminal
  function automatic logic [2:0] range_lo(input logic [2:0] f, input logic hi);
    logic [2:0] v;
    v = 3'h0;
    if ((f == mtr_pkg::FUNC_DCI) || (f == mtr_pkg::FUNC_ACI)) begin
      v = hi ? mtr_pkg::RANGE_AMP_MIN : mtr_pkg::RANGE_MA_MIN;
    end else if (f == mtr_pkg::FUNC_DIODE) begin
      v = mtr_pkg::RANGE_DIODE;
    end
    return v;
  endfunction

  function automatic logic [2:0] range_hi(input logic [2:0] f, input logic hi);
    logic [2:0] v;
    v = 3'h0;
    case (f)
      mtr_pkg::FUNC_DCV, mtr_pkg::FUNC_ACV: v = mtr_pkg::RANGE_VOLT_MAX;
      mtr_pkg::FUNC_OHMS, mtr_pkg::FUNC_CONT: v = mtr_pkg::RANGE_OHMS_MAX;
      mtr_pkg::FUNC_FREQ: v = mtr_pkg::RANGE_FREQ_MAX;
      mtr_pkg::FUNC_DCI, mtr_pkg::FUNC_ACI: v = hi ? mtr_pkg::RANGE_AMP_MAX : mtr_pkg::RANGE_MA_MAX;
      mtr_pkg::FUNC_DIODE: v = mtr_pkg::RANGE_DIODE;
      default: v = 3'h0;
    endcase
    return v;
  endfunction

  always_comb begin
    logic trig_accept;
    logic delayed;
    logic [2:0] lo;
    logic [2:0] hi;
    logic diode;
    logic bus_req;
    trig_accept = 1'b0;
    delayed = 1'b0;
    lo = 3'h0;
    hi = 3'h0;
    diode = 1'b0;
    bus_req = 1'b0;
    next_r = r;
    next_r.meas_start = 1'b0;

    // ==========================================================
    // Keys and menu
    if (key_shift) begin
      next_r.shift = 1'b1;
    end
    if (key_rate_trig) begin
      next_r.shift = 1'b0;
      if (r.shift) begin
        next_r.menu = 1'b1;
        next_r.menu_mode = r.trig_mode;
        next_r.hold_cnt = '0;
      end else if (!r.menu) begin
        if ((r.trig_mode == mtr_pkg::TRIG_KEY) || (r.trig_mode == mtr_pkg::TRIG_KEY_DELAY)) begin
          trig_accept = 1'b1;
        end else begin
          next_r.rate_sel = (r.rate_sel == mtr_pkg::RATE_FAST) ? mtr_pkg::RATE_SLOW : r.rate_sel + 2'h1;
        end
      end
    end
    if (r.menu) begin
      if (key_up && (r.menu_mode < mtr_pkg::TRIG_EXT_DELAY)) begin
        next_r.menu_mode = r.menu_mode + 3'h1;
      end else if (key_down && (r.menu_mode > mtr_pkg::TRIG_INTERNAL)) begin
        next_r.menu_mode = r.menu_mode - 3'h1;
      end
      if (range_key_level) begin
        if (r.hold_cnt == 28'(HOLD_CYCLES - 1)) begin
          next_r.trig_mode = r.menu_mode;
          next_r.menu = 1'b0;
          next_r.hold_cnt = '0;
        end else begin
          next_r.hold_cnt = r.hold_cnt + 28'h1;
        end
      end else begin
        next_r.hold_cnt = '0;
      end
      if (func_key_valid || mod_key_valid) begin
        next_r.menu = 1'b0;
      end
    end else begin
      lo = range_lo(r.func, r.amp_group);
      hi = range_hi(r.func, r.amp_group);
      if (key_range && (r.func != mtr_pkg::FUNC_DIODE)) begin
        next_r.auto_range = ~r.auto_range;
      end else if ((key_up || key_down) && (r.func != mtr_pkg::FUNC_DIODE)) begin
        next_r.auto_range = 1'b0;
        if (key_up && (r.range < hi)) begin
          next_r.range = r.range + 3'h1;
        end else if (key_down && (r.range > lo)) begin
          next_r.range = r.range - 3'h1;
        end
      end
    end

    // ==========================================================
    // Function, secondary display and modifiers
    if (func_key_valid) begin
      next_r.func_chosen = 1'b1;
      next_r.mods = 4'h0;
      next_r.sec_on = 1'b0;
      next_r.overload = 1'b0;
      next_r.func = func_key_code;
      if (func_key_code == mtr_pkg::FUNC_OHMS) begin
        next_r.wire4 = ~r.wire4;
      end else if (func_key_code == mtr_pkg::FUNC_CONT || func_key_code == mtr_pkg::FUNC_DIODE) begin
        next_r.func = (r.func == mtr_pkg::FUNC_CONT) ? mtr_pkg::FUNC_DIODE : mtr_pkg::FUNC_CONT;
      end
      if (func_key_code != r.func) begin
        next_r.range = range_lo(func_key_code, r.amp_group);
        next_r.auto_range = 1'b1;
      end
    end else if (mod_key_valid && r.func_chosen) begin
      next_r.mods = r.mods | (4'h1 << mod_key_code);
    end
    if (sec_key_valid && (sec_key_code != mtr_pkg::FUNC_CONT) && (sec_key_code != mtr_pkg::FUNC_DIODE)) begin
      next_r.sec_func = sec_key_code;
      next_r.sec_on = 1'b1;
    end

    // ==========================================================
    // Terminal limits and forced settings
    next_r.amp_group = lead_10a & ~lead_ma | lead_10a;
    lo = range_lo(next_r.func, next_r.amp_group);
    hi = range_hi(next_r.func, next_r.amp_group);
    diode = (r.func == mtr_pkg::FUNC_DIODE);
    if (diode) begin
      next_r.range = mtr_pkg::RANGE_DIODE;
    end
    next_r.rate = (diode || r.func == mtr_pkg::FUNC_CONT) ? mtr_pkg::RATE_FAST : r.rate_sel;
    next_r.beeper = (r.func == mtr_pkg::FUNC_CONT) && meas_below_20_ohm;
    next_r.ext_annunc = (r.trig_mode == mtr_pkg::TRIG_EXT) || (r.trig_mode == mtr_pkg::TRIG_EXT_DELAY);

    // ==========================================================
    // Autoranging on each completed reading
    if (meas_done && !func_key_valid) begin
      if (diode) begin
        next_r.overload = meas_diode_over_2v;
      end else if (r.auto_range) begin
        next_r.overload = 1'b0;
        if (meas_over_full_scale) begin
          if (r.range < hi) begin
            next_r.range = r.range + 3'h1;
          end else begin
            next_r.overload = 1'b1;
          end
        end else if (meas_under_lower && (r.range > lo)) begin
          next_r.range = r.range - 3'h1;
        end
      end else begin
        next_r.overload = meas_over_full_scale;
      end
    end
    // Clamp last so no ranging step leaves the terminal group
    if (next_r.range > hi) begin
      next_r.range = hi;
    end else if (next_r.range < lo) begin
      next_r.range = lo;
    end

    // ==========================================================
    // Trigger sequencer
    if (ext_strobe && r.ext_annunc) begin
      trig_accept = 1'b1;
    end
    delayed = (r.trig_mode == mtr_pkg::TRIG_KEY_DELAY) || (r.trig_mode == mtr_pkg::TRIG_EXT_DELAY);
    case (r.trig_state)
      mtr_pkg::TRIG_ST_IDLE: begin
        if (r.trig_mode == mtr_pkg::TRIG_INTERNAL && !r.menu) begin
          next_r.meas_start = 1'b1;
          next_r.trig_state = mtr_pkg::TRIG_ST_MEASURE;
        end else if (trig_accept && delayed) begin
          next_r.delay_cnt = '0;
          next_r.trig_state = mtr_pkg::TRIG_ST_DELAY;
        end else if (trig_accept) begin
          next_r.meas_start = 1'b1;
          next_r.trig_state = mtr_pkg::TRIG_ST_MEASURE;
        end
      end
      mtr_pkg::TRIG_ST_DELAY: begin
        if (r.delay_cnt == 28'(DELAY_CYCLES - 1)) begin
          next_r.meas_start = 1'b1;
          next_r.trig_state = mtr_pkg::TRIG_ST_MEASURE;
        end else begin
          next_r.delay_cnt = r.delay_cnt + 28'h1;
        end
      end
      mtr_pkg::TRIG_ST_MEASURE: begin
        if (meas_done) begin
          next_r.trig_state = mtr_pkg::TRIG_ST_IDLE;
          next_r.pulse_cnt = 8'(mtr_pkg::TRIG_PULSE_CYCLES);
          next_r.done_count = r.done_count + 16'h1;
        end
      end
      default: next_r.trig_state = mtr_pkg::TRIG_ST_IDLE;
    endcase
    if (r.trig_state == mtr_pkg::TRIG_ST_MEASURE && meas_done) begin
      next_r.trig_out_n = 1'b0;
    end else if (r.pulse_cnt > 8'h1) begin
      next_r.pulse_cnt = r.pulse_cnt - 8'h1;
      next_r.trig_out_n = 1'b0;
    end else begin
      next_r.pulse_cnt = 8'h0;
      next_r.trig_out_n = 1'b1;
    end

    // ==========================================================
    // Avalon-MM slave: one wait cycle, then answer
    bus_req = avs_read | avs_write;
    next_r.waitrequest = ~(bus_req & r.waitrequest);
    if (avs_read && r.waitrequest) begin
      case (avs_address)
        mtr_pkg::REG_CONTROL: next_r.readdata = {29'h0, r.trig_mode};
        mtr_pkg::REG_STATUS: next_r.readdata = {9'h0, r.wire4, r.amp_group, r.menu, r.mods,
                                               2'h0, r.overload, r.auto_range, 1'b0, r.range,
                                               1'b0, r.func, 1'b0, r.trig_state};
        mtr_pkg::REG_DONE_COUNT: next_r.readdata = {16'h0, r.done_count};
        default: next_r.readdata = 32'h0;
      endcase
    end
    if (avs_write && !r.waitrequest && avs_byteenable[0] && (avs_address == mtr_pkg::REG_CONTROL)) begin
      if ((avs_writedata[2:0] >= mtr_pkg::TRIG_INTERNAL) && (avs_writedata[2:0] <= mtr_pkg::TRIG_EXT_DELAY)) begin
        next_r.trig_mode = avs_writedata[2:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
      r.trig_state <= mtr_pkg::TRIG_ST_IDLE;
      r.trig_mode <= mtr_pkg::TRIG_MODE_RESET;
      r.menu_mode <= mtr_pkg::TRIG_MODE_RESET;
      r.trig_out_n <= 1'b1;
      r.range <= mtr_pkg::RANGE_RESET;
      r.auto_range <= 1'b1;
      r.waitrequest <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================
  // Outputs
  assign avs_readdata = r.readdata;
  assign avs_waitrequest = r.waitrequest;
  assign trig_out_n = r.trig_out_n;
  assign meas_start = r.meas_start;
  assign func = r.func;
  assign range = r.range;
  assign auto_range = r.auto_range;
  assign overload_indication = r.overload;
  assign wire4_annunc = r.wire4;
  assign amp_group_annunc = r.amp_group;
  assign ext_trig_annunc = r.ext_annunc;
  assign rate = r.rate;
  assign mods_active = r.mods;
  assign sec_func = r.sec_func;
  assign sec_on = r.sec_on;
  assign menu_active = r.menu;
  assign menu_mode = r.menu_mode;
  assign beeper = r.beeper;

endmodule // mtr_ctrl

`default_nettype wire

//--- core/mtr_pkg.sv
// Shared constants for the meter trigger, range and function control
package mtr_pkg;

  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned TRIG_DELAY_MS = 400;
  localparam int unsigned TRIG_DELAY_CYCLES = TRIG_DELAY_MS * (CLK_HZ / 1000);
  localparam int unsigned COMMIT_HOLD_MS = 2000;
  localparam int unsigned COMMIT_HOLD_CYCLES = COMMIT_HOLD_MS * (CLK_HZ / 1000);
  localparam int unsigned TRIG_PULSE_NS = 1000;
  localparam int unsigned TRIG_PULSE_CYCLES = (TRIG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // Trigger modes
  localparam logic [2:0] TRIG_INTERNAL = 3'h1;
  localparam logic [2:0] TRIG_KEY = 3'h2;
  localparam logic [2:0] TRIG_KEY_DELAY = 3'h3;
  localparam logic [2:0] TRIG_EXT = 3'h4;
  localparam logic [2:0] TRIG_EXT_DELAY = 3'h5;
  localparam logic [2:0] TRIG_MODE_RESET = 3'h1;

  // ==========================================================
  // Measurement functions
  localparam logic [2:0] FUNC_DCV = 3'h0;
  localparam logic [2:0] FUNC_ACV = 3'h1;
  localparam logic [2:0] FUNC_OHMS = 3'h2;
  localparam logic [2:0] FUNC_FREQ = 3'h3;
  localparam logic [2:0] FUNC_DCI = 3'h4;
  localparam logic [2:0] FUNC_ACI = 3'h5;
  localparam logic [2:0] FUNC_CONT = 3'h6;
  localparam logic [2:0] FUNC_DIODE = 3'h7;

  // ==========================================================
  // Range indices per function
  localparam logic [2:0] RANGE_VOLT_MAX = 3'h4;
  localparam logic [2:0] RANGE_OHMS_MAX = 3'h6;
  localparam logic [2:0] RANGE_FREQ_MAX = 3'h4;
  localparam logic [2:0] RANGE_MA_MIN = 3'h0;
  localparam logic [2:0] RANGE_MA_MAX = 3'h3;
  localparam logic [2:0] RANGE_AMP_MIN = 3'h4;
  localparam logic [2:0] RANGE_AMP_MAX = 3'h5;
  localparam logic [2:0] RANGE_DIODE = 3'h1;
  localparam logic [2:0] RANGE_RESET = 3'h0;

  // ==========================================================
  // Measurement rates
  localparam logic [1:0] RATE_SLOW = 2'h0;
  localparam logic [1:0] RATE_FAST = 2'h2;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [3:0] REG_CONTROL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_DONE_COUNT = 4'h8;

  // ==========================================================
  // Trigger sequencer states
  typedef enum logic [2:0] {
    TRIG_ST_IDLE = 3'h1,
    TRIG_ST_DELAY = 3'h2,
    TRIG_ST_MEASURE = 3'h4
  } mtr_trig_state_type;

endpackage

//--- core/mtr_trig_sync.sv
// Trigger input synchroniser and rising edge strobe
`timescale 1ns/1ps
`default_nettype none

module mtr_trig_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Raw trigger and strobe
  input wire logic trig_in,
  output logic trig_strobe
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic strobe;
  } mtr_sync_reg_type;

  mtr_sync_reg_type r;
  mtr_sync_reg_type next_r;

  always_comb begin
    next_r = r;
    next_r.s1 = trig_in;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    next_r.strobe = r.s2 & ~r.s3;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign trig_strobe = r.strobe;

endmodule // mtr_trig_sync

`default_nettype wire

//--- sim/mtr_ctrl_monitor.sv
// Port-level assertions for the meter control block
`timescale 1ns/1ps
`default_nettype none

module mtr_ctrl_monitor #(
  parameter int unsigned DELAY_CYCLES = 20,
  parameter int unsigned HOLD_CYCLES = 10
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Keys
  input wire logic func_key_valid,
  input wire logic [2:0] func_key_code,
  input wire logic key_range,
  input wire logic key_up,
  input wire logic key_down,
  // Engine
  input wire logic meas_done,
  input wire logic meas_over_full_scale,
  input wire logic meas_below_20_ohm,
  input wire logic meas_diode_over_2v,
  input wire logic lead_10a,
  input wire logic meas_start,
  input wire logic trig_out_n,
  // Display
  input wire logic [2:0] func,
  input wire logic [2:0] range,
  input wire logic auto_range,
  input wire logic overload_indication,
  input wire logic wire4_annunc,
  input wire logic amp_group_annunc,
  input wire logic [1:0] rate,
  input wire logic [3:0] mods_active,
  input wire logic [2:0] sec_func,
  input wire logic sec_on,
  input wire logic menu_active,
  input wire logic beeper
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ==========================================================
  // Assertions
  AST_START_ONE: assert property (meas_start |=> !meas_start) else $error("start longer than one cycle");
  AST_DONE_OUT: assert property ($fell(trig_out_n) |-> $past(meas_done)) else $error("stray done pulse");
  AST_DONE_LEN: assert property ($fell(trig_out_n) |=> !trig_out_n [*8]) else $error("done pulse short");
  AST_BEEP: assert property (func == mtr_pkg::FUNC_CONT && meas_below_20_ohm && !func_key_valid |=> beeper)
    else $error("no continuity tone");
  AST_DIODE: assert property (meas_done && func == mtr_pkg::FUNC_DIODE && !func_key_valid |=>
    range == mtr_pkg::RANGE_DIODE && rate == mtr_pkg::RATE_FAST && overload_indication == $past(meas_diode_over_2v))
    else $error("diode settings wrong");
  AST_WIRE4: assert property (func_key_valid && func_key_code == mtr_pkg::FUNC_OHMS |=>
    wire4_annunc != $past(wire4_annunc)) else $error("wire mode not toggled");
  AST_CLEAR: assert property (func_key_valid |=> mods_active == 4'h0 && !sec_on) else $error("mods kept");
  AST_SEC: assert property (sec_on |-> sec_func != mtr_pkg::FUNC_CONT && sec_func != mtr_pkg::FUNC_DIODE)
    else $error("test function on secondary");
  AST_AMP_GRP: assert property (!$past(rst) |-> amp_group_annunc == $past(lead_10a)) else $error("group lamp");
  AST_AMP_RNG: assert property ((func == mtr_pkg::FUNC_DCI || func == mtr_pkg::FUNC_ACI) && $stable(func)
    && lead_10a && $past(lead_10a) && !$past(rst) |-> range >= mtr_pkg::RANGE_AMP_MIN) else $error("amp range");
  AST_MAN_OVL: assert property (meas_done && !auto_range && func == mtr_pkg::FUNC_FREQ && !func_key_valid
    && !key_range && !key_up && !key_down |=> overload_indication == $past(meas_over_full_scale))
    else $error("manual overload wrong");
  AST_UP: assert property (key_up && auto_range && !menu_active && func == mtr_pkg::FUNC_FREQ && !key_range
    && range < mtr_pkg::RANGE_FREQ_MAX && !meas_done && !func_key_valid |=> !auto_range && range == $past(range) + 3'h1)
    else $error("up from auto wrong");

  // ==========================================================
  // Coverage
  CV_START: cover property (meas_start);
  CV_DONE: cover property ($fell(trig_out_n));
  CV_DIODE: cover property (meas_done && func == mtr_pkg::FUNC_DIODE);
endmodule // mtr_ctrl_monitor

bind mtr_ctrl mtr_ctrl_monitor #(.DELAY_CYCLES(DELAY_CYCLES), .HOLD_CYCLES(HOLD_CYCLES)) u_mon (
  .clk, .rst, .func_key_valid, .func_key_code, .key_range, .key_up, .key_down, .meas_done,
  .meas_over_full_scale, .meas_below_20_ohm, .meas_diode_over_2v, .lead_10a, .meas_start, .trig_out_n,
  .func, .range, .auto_range, .overload_indication, .wire4_annunc, .amp_group_annunc, .rate,
  .mods_active, .sec_func, .sec_on, .menu_active, .beeper);

`default_nettype wire

//--- sim/mtr_partner.sv
// Trigger source and measurement engine model
`timescale 1ns/1ps
`default_nettype none

module mtr_partner (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bench controls
  input wire logic fire,
  input wire logic slow,
  // Device side
  input wire logic meas_start,
  output logic ext_trig_in,
  output logic meas_done
);
  int cnt;

  always_ff @(posedge clk) begin
    ext_trig_in <= fire;
    meas_done <= 1'b0;
    if (rst) begin
      cnt <= 0;
    end else if (meas_start) begin
      cnt <= slow ? 180 : 140; // Engine outlasts the completion pulse
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      meas_done <= (cnt == 1);
    end
  end
endmodule // mtr_partner

`default_nettype wire

//--- sim/tb_meter_trigger_range_control.sv
// Self-checking bench for the meter control block
`timescale 1ns/1ps
`default_nettype none

module tb_meter_trigger_range_control;
  localparam int DLY = 20;
  localparam int HLD = 10;
  logic clk, rst, avs_read, avs_write, avs_waitrequest, range_key_level, fire, slow, w, tp;
  logic [3:0] avs_address, mods_active;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [7:0] kv;
  logic [2:0] kc, func, range, sec_func, menu_mode;
  logic [1:0] rate;
  logic ext_trig_in, trig_out_n, meas_start, meas_done, ovf, below20, over2v, lead_ma, lead_10a, under;
  logic auto_range, overload_indication, wire4_annunc, amp_group_annunc, ext_trig_annunc, sec_on, menu_active, beeper;
  int miscompares, n_tests, cycles, seed, n, s, i, n_start, n_done, n_fall;
  int lat [6];

  mtr_ctrl #(.DELAY_CYCLES(DLY), .HOLD_CYCLES(HLD)) uut (
    .clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata,
    .avs_waitrequest, .func_key_valid(kv[0]), .func_key_code(kc), .sec_key_valid(kv[1]), .sec_key_code(kc),
    .mod_key_valid(kv[2]), .mod_key_code(kc[1:0]), .key_range(kv[3]), .range_key_level, .key_up(kv[4]),
    .key_down(kv[5]), .key_shift(kv[6]), .key_rate_trig(kv[7]), .ext_trig_in, .trig_out_n, .meas_start,
    .meas_done, .meas_over_full_scale(ovf), .meas_under_lower(under), .meas_below_20_ohm(below20),
    .meas_diode_over_2v(over2v), .lead_ma, .lead_10a, .func, .range, .auto_range, .overload_indication,
    .wire4_annunc, .amp_group_annunc, .ext_trig_annunc, .rate, .mods_active, .sec_func, .sec_on,
    .menu_active, .menu_mode, .beeper);

  mtr_partner u_far (.clk, .rst, .fire, .slow, .meas_start, .ext_trig_in, .meas_done);

  task automatic complete_run();
    $display("Comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask

  // One-cycle key strobe
  task automatic key(input int k, input logic [2:0] c);
    kc <= c;
    kv <= 8'h01 << k;
    @(posedge clk);
    kv <= 8'h00;
    @(posedge clk);
  endtask

  task automatic wait_done();
    @(posedge clk);
    while (meas_done !== 1'b1) @(posedge clk);
    @(posedge clk);
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ==========================================================
  // Reference counts and timeout
  always @(posedge clk) begin
    cycles++;
    tp <= trig_out_n;
    if (meas_start === 1'b1) n_start++;
    if (meas_done === 1'b1) n_done++;
    if (tp === 1'b1 && trig_out_n === 1'b0) n_fall++;
    if (cycles == 30000) begin
      miscompares++;
      complete_run();
    end
  end

  // ==========================================================
  // Scenarios
  initial begin
    seed = 11;
    {rst, kv, kc, avs_read, avs_write, avs_address, avs_writedata} = '0;
    {range_key_level, fire, slow, ovf, below20, over2v, lead_ma, lead_10a, under} = '0;
    rst = 1'b1;
    repeat (4) @(posedge clk);
    chk({func, range, auto_range, trig_out_n, menu_mode}, 11'h019);
    rst <= 1'b0;
    key(2, 3'h1);
    chk(mods_active, 32'h0);
    repeat (800) @(posedge clk);
    chk(n_start >= 5, 1);
    slow <= 1'b1;
    for (i = 2; i <= 5; i++) begin
      bus(1'b1, mtr_pkg::REG_CONTROL, i);
      @(posedge clk);
      chk(ext_trig_annunc, i >= 4);
      repeat (250) @(posedge clk);
      s = n_start;
      n = 1;
      if (i < 4) kv <= 8'h80;
      else fire <= 1'b1;
      @(posedge clk);
      kv <= 8'h00;
      while (meas_start !== 1'b1 && n < 100) begin
        @(posedge clk);
        n++;
      end
      lat[i] = n;
      if (i < 4) key(7, 3'h0);
      else begin
        fire <= 1'b0;
        @(posedge clk);
        fire <= 1'b1;
        @(posedge clk);
      end
      repeat (DLY + 250) @(posedge clk);
      fire <= 1'b0;
      chk(n_start - s, 1);
    end
    chk(lat[3] - lat[2], DLY);
    chk(lat[5] - lat[4], DLY);
    chk(lat[2] <= 2 && lat[4] <= 8, 1);
    bus(1'b0, mtr_pkg::REG_DONE_COUNT, 0);
    chk(rd[15:0], n_done[15:0]);
    chk(n_fall, n_done);
    bus(1'b0, mtr_pkg::REG_STATUS, 0);
    chk(rd, 32'h00001001);
    bus(1'b0, 4'hC, 0);
    chk(rd, 32'h0);
    bus(1'b1, mtr_pkg::REG_CONTROL, 6);
    bus(1'b0, mtr_pkg::REG_CONTROL, 0);
    chk(rd[2:0], 3'h5);
    key(6, 3'h0);
    key(7, 3'h0);
    chk({menu_active, menu_mode}, 4'hD);
    repeat (5) key(5, 3'h0);
    key(4, 3'h0);
    chk(menu_mode, 3'h2);
    range_key_level <= 1'b1;
    repeat (HLD - 2) @(posedge clk);
    range_key_level <= 1'b0;
    @(posedge clk);
    chk(menu_active, 1'b1);
    range_key_level <= 1'b1;
    repeat (HLD + 3) @(posedge clk);
    range_key_level <= 1'b0;
    @(posedge clk);
    bus(1'b0, mtr_pkg::REG_CONTROL, 0);
    chk({menu_active, rd[2:0]}, 4'h2);
    bus(1'b1, mtr_pkg::REG_CONTROL, 1);
    slow <= 1'b0;
    key(0, mtr_pkg::FUNC_OHMS);
    w = wire4_annunc;
    key(0, mtr_pkg::FUNC_OHMS);
    chk(wire4_annunc, !w);
    key(0, mtr_pkg::FUNC_CONT);
    key(0, mtr_pkg::FUNC_CONT);
    chk(func, mtr_pkg::FUNC_DIODE);
    key(1, mtr_pkg::FUNC_CONT);
    chk(sec_on, 1'b0);
    over2v <= 1'($random(seed));
    repeat (160) @(posedge clk);
    chk({range, rate, overload_indication}, {mtr_pkg::RANGE_DIODE, mtr_pkg::RATE_FAST, over2v});
    key(0, mtr_pkg::FUNC_CONT);
    below20 <= 1'b1;
    repeat (3) @(posedge clk);
    chk({func, beeper}, 4'hD);
    below20 <= 1'b0;
    repeat (3) @(posedge clk);
    chk(beeper, 1'b0);
    key(0, mtr_pkg::FUNC_FREQ);
    ovf <= 1'b1;
    wait_done();
    ovf <= 1'b0;
    chk(range, 3'h1);
    under <= 1'b1;
    wait_done();
    under <= 1'b0;
    chk(range, 3'h0);
    key(4, 3'h0);
    chk({auto_range, range}, 4'h1);
    ovf <= 1'b1;
    wait_done();
    chk({overload_indication, range}, 4'h9);
    ovf <= 1'b0;
    wait_done();
    chk(overload_indication, 1'b0);
    lead_ma <= 1'b1;
    key(0, mtr_pkg::FUNC_DCI);
    ovf <= 1'b1;
    repeat (600) @(posedge clk);
    chk(range <= mtr_pkg::RANGE_MA_MAX, 1);
    lead_10a <= 1'b1;
    repeat (5) @(posedge clk);
    chk({amp_group_annunc, range >= mtr_pkg::RANGE_AMP_MIN, range <= mtr_pkg::RANGE_AMP_MAX}, 3'h7);
    ovf <= 1'b0;
    key(2, 3'($random(seed)));
    chk(mods_active != 4'h0, 1);
    key(1, mtr_pkg::FUNC_ACV);
    chk(sec_on, 1'b1);
    key(0, mtr_pkg::FUNC_DCV);
    chk({mods_active, sec_on}, 5'h0);
    complete_run();
  end
endmodule // tb_meter_trigger_range_control

`default_nettype wire
